// ==== fuse_prog.v ====
// parallel programming engine for fuses, protection bits and id bytes
//
// Summary of operation
// RULE_01: the programmer writes the fuse high byte with the fuse write command, byte_select_one high.
// RULE_02: a written data bit of 0 programs its fuse and a 1 erases it.
// RULE_03: with byte_select_one low and byte_select_two high the fuse write goes to the extended byte.
// RULE_04: the programmer writes protection bits with the protection command, 0 meaning program.
// RULE_05: once both level bits are programmed the boot protection bits cannot be programmed.
// RULE_06: programmed protection bits return to erased only through chip erase; the code also erases them on reset.
// RULE_07: the programmer reads fuses with the fuse read command while holding read_drive_n low.
// RULE_08: the two byte selects choose fuse low, fuse high, extended fuse or protection byte.
// RULE_09: on readback a programmed bit shows as 0 and an unprogrammed one as 1.
// RULE_10: with the signature command, address 0 to 2 and byte_select_one low, a signature byte is read.
// RULE_11: with the signature command, address 0 and byte_select_one high, the calibration byte is read.
// RULE_12: after a write pulse done_flag falls within 1 us and rises 3.7 to 4.5 ms later.
// RULE_13: after a chip erase pulse done_flag rises 7.5 to 9 ms later.
// RULE_14: while done_flag is low, write pulses and command loads are ignored.
// RULE_15: data is driven only while read_drive_n is low and a read command is active.
`timescale 1ns/1ns
`include "fuse_prog_map.vh"
module fuse_prog #(
    parameter [19:0] WRITE_CYCLES = `WRITE_CYCLES,
    parameter [19:0] ERASE_CYCLES = `ERASE_CYCLES,
    parameter [7:0] SIG_BYTE0 = 8'h11, // arbitrary value
    parameter [7:0] SIG_BYTE1 = 8'h22, // arbitrary value
    parameter [7:0] SIG_BYTE2 = 8'h33, // arbitrary value
    parameter [7:0] CAL_BYTE = 8'h80 // arbitrary value
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // load strobes from the programmer, one cycle each
    input wire load_command,
    input wire load_address,
    input wire load_data,
    input wire [7:0] data_in,
    // control pins
    input wire byte_select_one,
    input wire byte_select_two,
    input wire program_pulse_n,
    input wire read_drive_n,
    // data bus output side
    output reg [7:0] data_out,
    output wire data_oe_n,
    // status
    output wire done_flag,
    // stored bytes for the rest of the chip
    output wire [7:0] fuse_low,
    output wire [7:0] fuse_high,
    output wire [7:0] fuse_ext,
    output wire [7:0] prot_bits
);

// one-hot operation states
// idle is the only state that accepts loads and strobes
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_WRITE = 3'b010;
localparam [2:0] ST_ERASE = 3'b100;

reg rst_s1_reg;
reg rst_s2_reg;
wire rst_n;
reg [7:0] cmd_reg;
reg [7:0] addr_reg;
reg [7:0] data_reg;
reg [7:0] fuse_low_reg;
reg [7:0] fuse_high_reg;
reg [7:0] fuse_ext_reg;
reg [7:0] prot_reg;
reg [2:0] state_reg;
reg [2:0] state_next;
reg pulse_d_reg;
reg [7:0] read_mux;
wire pulse_fall;
wire timer_busy;
wire idle;
wire level3;
wire timer_start;
wire [19:0] timer_load;

// two-stage reset release
// asserts at once, releases only on a clock edge so no flop sees a runt
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rst_s1_reg <= 1'b0;
        rst_s2_reg <= 1'b0;
    end else begin
        rst_s1_reg <= 1'b1;
        rst_s2_reg <= rst_s1_reg;
    end
end
assign rst_n = rst_s2_reg;

// program a bit only where new data is 0; erased bits stay as stored
function [7:0] merge_program;
    input [7:0] stored;
    input [7:0] wdata;
    begin
        merge_program = stored & wdata;
    end
endfunction

// true for the two commands that turn the data pins around
function is_read_cmd;
    input [7:0] cmd;
    begin
        is_read_cmd = (cmd == `CMD_READ_FUSE) || (cmd == `CMD_READ_SIG);
    end
endfunction

// signature bytes by address; anything past the last one reads erased
function [7:0] sig_byte;
    input [7:0] addr;
    begin
        case (addr)
            8'h00: sig_byte = SIG_BYTE0;
            8'h01: sig_byte = SIG_BYTE1;
            `SIG_ADDR_MAX: sig_byte = SIG_BYTE2;
            default: sig_byte = 8'hFF;
        endcase
    end
endfunction

// fuse readback by {two, one}: 00 low, 11 high, 10 extended, 01 protection
function [7:0] fuse_pick;
    input [1:0] sel;
    input [7:0] f_low;
    input [7:0] f_high;
    input [7:0] f_ext;
    input [7:0] f_prot;
    begin
        case (sel)
            2'b00: fuse_pick = f_low;
            2'b11: fuse_pick = f_high;
            2'b10: fuse_pick = f_ext;
            default: fuse_pick = f_prot;
        endcase
    end
endfunction

// level 3 means both level bits programmed, i.e. read as 0
// boot protection bits sit at 5:2, above the two level bits
assign level3 = (prot_reg[`PROT_LEVEL_LSB + 1:`PROT_LEVEL_LSB] == 2'b00);
assign idle = (state_reg == ST_IDLE);

// falling edge of the write strobe
// reset to the pin's idle level so a quiet pin gives no false edge
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        pulse_d_reg <= 1'b1;
    end else begin
        pulse_d_reg <= program_pulse_n;
    end
end
assign pulse_fall = pulse_d_reg & ~program_pulse_n;

// command, address and data latches; frozen while busy
// a load arriving mid-operation is lost; the programmer must wait for done
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cmd_reg <= 8'h00;
        addr_reg <= 8'h00;
        data_reg <= 8'hFF;
    end else if (idle) begin // RULE_14
        if (load_command) begin
            cmd_reg <= data_in;
        end
        if (load_address) begin
            addr_reg <= data_in;
        end
        if (load_data) begin
            data_reg <= data_in;
        end
    end
end

// operation sequencer
// write and erase differ only in their timer load; both wait for the timer
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            if (pulse_fall && cmd_reg == `CMD_CHIP_ERASE) begin
                state_next = ST_ERASE;
            end else if (pulse_fall) begin
                state_next = ST_WRITE;
            end
        end
        ST_WRITE: begin
            if (!timer_busy) begin
                state_next = ST_IDLE;
            end
        end
        ST_ERASE: begin
            if (!timer_busy) begin
                state_next = ST_IDLE;
            end
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        state_reg <= ST_IDLE;
    end else begin
        state_reg <= state_next;
    end
end

// timer starts on the accepted pulse only; pulses while busy are dropped
assign timer_start = idle & pulse_fall; // RULE_14
// erase needs about twice the write time, so it loads its own count
assign timer_load = (cmd_reg == `CMD_CHIP_ERASE) ? ERASE_CYCLES : WRITE_CYCLES; // RULE_12 RULE_13

// one shared timer: write and erase never overlap
busy_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(timer_start),
    .load_count(timer_load),
    .busy(timer_busy)
);

// done goes low one cycle after the pulse edge, well inside 1 us
assign done_flag = idle; // RULE_12 RULE_13

// nonvolatile byte updates, committed at the pulse so reads see them at once
// fuse bytes take the new data whole: a 1 erases, a 0 programs
// protection writes only move bits toward programmed, through merge_program
// a fuse write with both selects high has no target and is dropped
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        fuse_low_reg <= `FUSE_LOW_RST;
        fuse_high_reg <= `FUSE_HIGH_RST;
        fuse_ext_reg <= `FUSE_EXT_RST;
        prot_reg <= `PROT_RST;
    end else if (timer_start) begin
        case (cmd_reg)
            `CMD_WRITE_FUSE: begin
                if (byte_select_one && !byte_select_two) begin // RULE_01
                    fuse_high_reg <= data_reg; // RULE_02
                end else if (!byte_select_one && byte_select_two) begin // RULE_03
                    fuse_ext_reg <= data_reg; // RULE_02
                end else if (!byte_select_one && !byte_select_two) begin
                    fuse_low_reg <= data_reg;
                end else begin
                    fuse_low_reg <= fuse_low_reg; // both selects high: no target
                end
            end
            `CMD_WRITE_PROT: begin
                // bits only move toward programmed here; chip erase or reset clears
                if (level3) begin
                    prot_reg <= merge_program(prot_reg, data_reg
                        | 8'h3C); // RULE_05 RULE_06
                end else begin
                    prot_reg <= merge_program(prot_reg, data_reg); // RULE_04 RULE_06
                end
            end
            `CMD_CHIP_ERASE: begin
                prot_reg <= `PROT_RST; // RULE_06
            end
            default: begin
                prot_reg <= prot_reg;
            end
        endcase
    end
end

// readback selection; stored bytes already use 0 for programmed
// other commands read all ones; the pins stay released for them anyway
always @* begin
    read_mux = 8'hFF;
    if (cmd_reg == `CMD_READ_FUSE) begin
        read_mux = fuse_pick({byte_select_two, byte_select_one}, fuse_low_reg, // RULE_08
            fuse_high_reg, fuse_ext_reg, prot_reg); // RULE_09
    end else if (cmd_reg == `CMD_READ_SIG) begin
        if (byte_select_one) begin
            read_mux = CAL_BYTE; // RULE_11
        end else begin
            read_mux = sig_byte(addr_reg); // RULE_10
        end
    end
end

// registered data output
// one cycle behind the selects, well inside the read access time
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        data_out <= 8'hFF;
    end else begin
        data_out <= read_mux;
    end
end

// drive only for an active read command with read_drive_n low; kept
// combinational so the pins release without the data register delay
assign data_oe_n = read_drive_n | ~is_read_cmd(cmd_reg); // RULE_15

// stored bytes for the fuse consumers in the rest of the chip
assign fuse_low = fuse_low_reg;
assign fuse_high = fuse_high_reg;
assign fuse_ext = fuse_ext_reg;
assign prot_bits = prot_reg;

endmodule // fuse_prog

// ==== fuse_prog_map.vh ====
// constants for the parallel fuse and protection programming block
`ifndef FUSE_PROG_MAP_VH
`define FUSE_PROG_MAP_VH

// command codes latched by the programmer
`define CMD_WRITE_FUSE 8'h40
`define CMD_WRITE_PROT 8'h20
`define CMD_READ_FUSE 8'h04
`define CMD_READ_SIG 8'h08
`define CMD_CHIP_ERASE 8'h80

// erased (unprogrammed) values of the stored bytes
`define FUSE_LOW_RST 8'hFF
`define FUSE_HIGH_RST 8'hFF
`define FUSE_EXT_RST 8'hFF
`define PROT_RST 8'hFF

// protection byte fields
`define PROT_LEVEL_LSB 0
`define PROT_BOOT_LSB 2
`define PROT_BOOT_MSB 5

// signature address range
`define SIG_ADDR_MAX 8'h02

// clock and write timing
`define CLK_PERIOD_NS 10
`define T_BUSY_LOW_MAX_US 1
`define T_WRITE_MIN_US 3700
`define T_WRITE_MAX_US 4500
`define T_ERASE_MIN_US 7500
`define T_ERASE_MAX_US 9000
// midpoint of each window as clock cycles: 4100 us and 8250 us at 10 ns
// sized to the timer width so no parameter is cut silently
`define WRITE_CYCLES 20'h64190
`define ERASE_CYCLES 20'hC96A8

`endif

// ==== busy_timer.v ====
// down counter that times one nonvolatile write or erase
`timescale 1ns/1ns
module busy_timer (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // control
    input wire start,
    input wire [19:0] load_count,
    // status
    output wire busy
);

reg [19:0] count_reg;

// count down to zero; a start while running is never issued by the owner
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        count_reg <= 20'h00000;
    end else if (start) begin
        count_reg <= load_count;
    end else if (count_reg != 20'h00000) begin
        count_reg <= count_reg - 20'h00001;
    end
end

assign busy = (count_reg != 20'h00000);

endmodule // busy_timer

// ==== fuse_prog_assertions.sv ====
// port-level checker for the fuse programming block
`timescale 1ns/1ns
`include "fuse_prog_map.vh"
module fuse_prog_checker #(
    parameter [19:0] WRITE_CYCLES = 20'h00014,
    parameter [19:0] ERASE_CYCLES = 20'h00028
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // programmer side
    input wire load_command,
    input wire load_address,
    input wire load_data,
    input wire [7:0] data_in,
    input wire byte_select_one,
    input wire byte_select_two,
    input wire program_pulse_n,
    input wire read_drive_n,
    // device side
    input wire [7:0] data_out,
    input wire data_oe_n,
    input wire done_flag,
    input wire [7:0] fuse_low,
    input wire [7:0] fuse_high,
    input wire [7:0] fuse_ext,
    input wire [7:0] prot_bits
);
    reg [7:0] cmd_reg;
    reg [19:0] low_reg;
    wire [31:0] stores = {fuse_low, fuse_high, fuse_ext, prot_bits};
    // loads during busy are dropped, so the copy follows the same gate
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_reg <= 8'h00;
            low_reg <= 20'h00000;
        end else begin
            if (load_command && done_flag) cmd_reg <= data_in;
            low_reg <= done_flag ? 20'h00000 : low_reg + 20'h00001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_OE_OFF: assert property (read_drive_n |-> data_oe_n)
        else $error("data driven while read released");
    AST_OE_ON: assert property (!read_drive_n && (cmd_reg == `CMD_READ_FUSE
        || cmd_reg == `CMD_READ_SIG) |-> !data_oe_n) else $error("read not driven");
    AST_DONE_FALL: assert property ($fell(program_pulse_n) && done_flag
        |-> ##[1:3] !done_flag) else $error("done did not fall");
    AST_DONE_TIME: assert property ($rose(done_flag) |->
        (low_reg >= WRITE_CYCLES && low_reg <= WRITE_CYCLES + 20'h00002) ||
        (low_reg >= ERASE_CYCLES && low_reg <= ERASE_CYCLES + 20'h00002))
        else $error("busy time out of range");
    AST_BUSY_HOLD: assert property (!done_flag |=> $stable(stores))
        else $error("stored byte changed while busy");
    AST_STORE_CAUSE: assert property (!$stable(stores) |-> $fell(done_flag))
        else $error("stored byte changed without a write");
    AST_PROT_ERASE: assert property ($fell(done_flag) &&
        (prot_bits & ~$past(prot_bits)) != 8'h00 |-> cmd_reg == `CMD_CHIP_ERASE)
        else $error("protection erased without chip erase");
    AST_LEVEL3: assert property (prot_bits[1:0] == 2'h0 && cmd_reg != `CMD_CHIP_ERASE
        |=> prot_bits[5:2] == $past(prot_bits[5:2])) else $error("boot bits changed");
    AST_FUSE_READ: assert property ($past(cmd_reg) == `CMD_READ_FUSE && done_flag
        && $stable({byte_select_two, byte_select_one}) |-> data_out == (byte_select_two ?
        (byte_select_one ? fuse_high : fuse_ext) : (byte_select_one ? prot_bits : fuse_low)))
        else $error("wrong byte on fuse read");
    COV_ERASE: cover property (cmd_reg == `CMD_CHIP_ERASE && $rose(done_flag));
    COV_LOCKED: cover property (prot_bits[1:0] == 2'h0 && $fell(done_flag));
    COV_SIG: cover property (!data_oe_n && cmd_reg == `CMD_READ_SIG);
endmodule // fuse_prog_checker

bind fuse_prog fuse_prog_checker #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES))
    i_chk (.*);

// ==== fuse_prog_programmer.sv ====
// model of the external parallel programmer
`timescale 1ns/1ns
module fuse_prog_programmer (
    // clock and status
    input wire clk,
    input wire done_flag,
    // loads
    output reg load_command,
    output reg load_address,
    output reg load_data,
    output reg [7:0] data_in,
    // control pins
    output reg byte_select_one,
    output reg byte_select_two,
    output reg program_pulse_n,
    output reg read_drive_n,
    // device never came back ready
    output reg hung
);
    initial {load_command, load_address, load_data, byte_select_one, byte_select_two} = 5'h00;
    initial {program_pulse_n, read_drive_n, hung, data_in} = {2'h3, 1'b0, 8'h00};
    // changes land just after a rising edge
    task step;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    // bus shows the inverse afterwards so a stale byte is never reused
    task ld(input [1:0] kind, input [7:0] val);
        begin
            data_in = val;
            {load_data, load_address, load_command} = 3'h1 << kind;
            step;
            {load_data, load_address, load_command} = 3'h0;
            data_in = ~val;
            // let an edge pass so the next load never re-raises a strobe at once
            step;
        end
    endtask
    // poke adds a load and a second pulse while busy
    task wr(input b2, input b1, input poke);
        integer i;
        begin
            {byte_select_two, byte_select_one} = {b2, b1};
            step;
            program_pulse_n = 1'b0;
            repeat (2) step;
            program_pulse_n = 1'b1;
            step;
            if (poke) begin
                ld(2'h2, 8'h00);
                program_pulse_n = 1'b0;
                repeat (2) step;
                program_pulse_n = 1'b1;
            end
            for (i = 0; i < 200 && done_flag !== 1'b1; i = i + 1) step;
            hung = done_flag !== 1'b1;
            {byte_select_two, byte_select_one} = 2'h0;
            step;
        end
    endtask
    task rd(input b2, input b1);
        begin
            {byte_select_two, byte_select_one} = {b2, b1};
            read_drive_n = 1'b0;
            repeat (3) step;
            read_drive_n = 1'b1;
            {byte_select_two, byte_select_one} = 2'h0;
            step;
        end
    endtask
endmodule // fuse_prog_programmer

// ==== fuse_prog_test.sv ====
// self-checking bench for the fuse programming block
`timescale 1ns/1ns
`include "fuse_prog_map.vh"
module fuse_prog_test;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    wire load_command, load_address, load_data, byte_select_one, byte_select_two;
    wire program_pulse_n, read_drive_n, data_oe_n, done_flag, hung;
    wire [7:0] data_in, data_out, fuse_low, fuse_high, fuse_ext, prot_bits;
    integer num_errors = 0;
    integer checks_done = 0;
    integer rd_cnt = 0;
    integer k;
    reg [31:0] rnd;
    reg [23:0] sig_bytes = 24'h3CA55A;
    reg [8:0] exp_q[$];
    always #5 clk = ~clk;
    // calibration byte stays at its default of 8'h80
    fuse_prog #(.WRITE_CYCLES(20'h00014), .ERASE_CYCLES(20'h00028), .SIG_BYTE0(8'h5A),
        .SIG_BYTE1(8'hA5), .SIG_BYTE2(8'h3C)) i_fuse_prog (.*);
    fuse_prog_programmer i_prog (.*);
    task finish_test;
        begin
            $display("errors %0d checks %0d", num_errors, checks_done);
            if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [8:0] got, input [8:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD %0t read got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // third held cycle of a read is the result; released bus compares as 9'h100
    always @(posedge clk) begin
        if (!read_drive_n && rd_cnt == 2) begin
            if (exp_q.size() == 0) chk(9'h1FF, 9'h000);
            else chk({data_oe_n, data_oe_n ? 8'h00 : data_out}, exp_q.pop_front());
        end
        rd_cnt = read_drive_n ? 0 : rd_cnt + 1;
        if (hung === 1'b1) begin
            num_errors = num_errors + 1;
            finish_test;
        end
    end
    task xrd(input b2, input b1, input [8:0] e);
        begin
            exp_q.push_back(e);
            i_prog.rd(b2, b1);
        end
    endtask
    task rd_all(input [31:0] e);
        begin
            i_prog.ld(2'h0, `CMD_READ_FUSE);
            xrd(1'b0, 1'b0, {1'b0, e[31:24]});
            xrd(1'b1, 1'b1, {1'b0, e[23:16]});
            xrd(1'b1, 1'b0, {1'b0, e[15:8]});
            xrd(1'b0, 1'b1, {1'b0, e[7:0]});
        end
    endtask
    task fw(input b2, input b1, input [7:0] val, input poke);
        begin
            i_prog.ld(2'h0, (b2 | b1) === 1'bx ? 8'h00 : `CMD_WRITE_FUSE);
            i_prog.ld(2'h2, val);
            i_prog.wr(b2, b1, poke);
        end
    endtask
    task pw(input [7:0] val);
        begin
            i_prog.ld(2'h0, `CMD_WRITE_PROT);
            i_prog.ld(2'h2, val);
            i_prog.wr(1'b0, 1'b0, 1'b0);
        end
    endtask
    initial begin
        rnd = $urandom(49);
        rnd = $urandom;
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (3) i_prog.step;
        rd_all(32'hFFFFFFFF);
        fw(1'b0, 1'b1, rnd[7:0], 1'b1);
        fw(1'b1, 1'b0, rnd[15:8], 1'b0);
        fw(1'b0, 1'b0, rnd[23:16], 1'b0);
        pw(8'hFC);
        pw(8'hC3);
        pw(8'hFF);
        rd_all({rnd[23:16], rnd[7:0], rnd[15:8], 8'hFC});
        i_prog.ld(2'h0, `CMD_CHIP_ERASE);
        i_prog.wr(1'b0, 1'b0, 1'b0);
        pw(8'hF3);
        rd_all({rnd[23:16], rnd[7:0], rnd[15:8], 8'hF3});
        i_prog.ld(2'h0, `CMD_READ_SIG);
        for (k = 0; k < 3; k = k + 1) begin
            i_prog.ld(2'h1, k[7:0]);
            xrd(1'b0, 1'b0, {1'b0, sig_bytes[k * 8 +: 8]});
        end
        i_prog.ld(2'h1, 8'h00);
        xrd(1'b0, 1'b1, 9'h080);
        i_prog.ld(2'h0, `CMD_WRITE_FUSE);
        xrd(1'b0, 1'b0, 9'h100);
        nrst = 1'b0;
        repeat (3) i_prog.step;
        nrst = 1'b1;
        repeat (3) i_prog.step;
        rd_all(32'hFFFFFFFF);
        finish_test;
    end
endmodule // fuse_prog_test
